// File: bench/host_sink.sv
// Host serial receiver model with random back-pressure
`timescale 1ns/100ps
`default_nettype none
module host_sink (
    // Clock and host stream
    input  wire logic       clk_i,
    input  wire logic       ser_valid_i,
    input  wire logic [7:0] ser_data_i,
    input  wire logic       ser_last_i,
    output var  logic       ser_ready_o
);
    logic [7:0] rx_q[$];
    logic [7:0] sum = 8'h00;
    int         frames = 0;
    int         bad = 0;
    int         seed = 32'h0000_707c;
    initial ser_ready_o = 1'b0;
    // Take bytes in order; stalls make the sender hold its byte
    always @(posedge clk_i) begin
        if (ser_valid_i && ser_ready_o) begin
            rx_q.push_back(ser_data_i);
            sum = (rx_q.size() > 3) ? sum + ser_data_i : 8'h00;
            if (ser_last_i === 1'b1) begin
                frames++;
                if (sum !== 8'hFF) bad++;
                if (rx_q.size() != {rx_q[1], rx_q[2]} + 4) bad++;
            end
        end
        ser_ready_o <= ($random(seed) % 4) != 0;
    end
endmodule : host_sink
`default_nettype wire

// File: bench/test_explicit_receive_frame_builder.sv
// Self-checking bench for the explicit receive frame builder
`timescale 1ns/100ps
`default_nettype none
module test_explicit_receive_frame_builder;
    import frame_pkg::*;
    // Ports and bench state
    logic        clk_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic        avs_waitrequest_o, pkt_valid_i = 1'b0, pkt_ready_o, pkt_zdo_i = 1'b0;
    logic        pay_valid_i = 1'b0, pay_ready_o, ser_valid_o, ser_last_o, rdy;
    logic [3:0]  avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = '0, avs_readdata_o, rd;
    logic [63:0] pkt_src64_i = '0;
    logic [15:0] pkt_src16_i = '0, pkt_cluster_i = '0, pkt_profile_i = '0, pkt_len_i = '0;
    byte_t       pkt_src_ep_i = '0, pkt_dst_ep_i = '0, pkt_options_i = '0;
    byte_t       pay_data_i = '0, ser_data_o;
    int          err_count = 0, check_count = 0, seed = 32'h0000_707c, nf = 0, nd = 0;
    logic [7:0]  exp_q[$], pay[$];
    byte_t       dep_tab[4] = '{8'hDC, 8'hEE, 8'hDB, 8'hEF};
    logic [31:0] modes[4] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0003, 32'h0000_0001};

    always #20 clk_i = ~clk_i;

    // Small payload limit so the oversize drop path is reachable in a short run
    explicit_receive_frame_builder #(.MAX_PAYLOAD(16'd6)) dut_u (.clk_i, .rst_b_i,
        .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .pkt_valid_i,
        .pkt_ready_o, .pkt_src64_i, .pkt_src16_i, .pkt_src_ep_i, .pkt_dst_ep_i, .pkt_cluster_i,
        .pkt_profile_i, .pkt_options_i, .pkt_zdo_i, .pkt_len_i, .pay_valid_i, .pay_data_i,
        .pay_ready_o, .ser_valid_o, .ser_data_o, .ser_last_o, .ser_ready_i(rdy));
    host_sink host_u (.clk_i, .ser_valid_i(ser_valid_o), .ser_data_i(ser_data_o),
        .ser_last_i(ser_last_o), .ser_ready_o(rdy));

    task finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    // Bounded wait step; a hang is counted and closes the run
    task tick(inout int n);
        @(posedge clk_i);
        n++;
        if (n > 500) begin
            cmp(0, 1, "timeout");
            finish_test();
        end
    endtask : tick

    // Avalon-MM access held until waitrequest is sampled low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do tick(n); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus

    // Expected frame from the descriptor that was driven
    function automatic void build(input logic ex);
        logic [7:0]  s;
        logic [15:0] len;
        s = 8'h00;
        len = (ex ? 16'd18 : 16'd12) + pkt_len_i;
        exp_q = {8'h7E, len[15:8], len[7:0], ex ? 8'h91 : 8'h90};
        for (int i = 7; i >= 0; i--) exp_q.push_back(pkt_src64_i[i*8+:8]);
        exp_q = {exp_q, pkt_src16_i[15:8], pkt_src16_i[7:0]};
        if (ex) exp_q = {exp_q, pkt_src_ep_i, pkt_dst_ep_i, pkt_cluster_i[15:8],
            pkt_cluster_i[7:0], pkt_profile_i[15:8], pkt_profile_i[7:0]};
        // Reserved option bits vanish; in explicit frames outside vendor endpoints only ack/broadcast remain
        exp_q.push_back(pkt_options_i & ((ex && !(pkt_dst_ep_i inside {[8'hDC:8'hEE]}))
            ? 8'h03 : 8'hF3));
        exp_q = {exp_q, pay};
        for (int i = 3; i < exp_q.size(); i++) s += exp_q[i];
        exp_q.push_back(8'hFF - s);
    endfunction : build

    // One packet in, then its frame (or silence on a drop) checked
    task frame(input logic ex, input logic zdo, input int n, input byte_t dep);
        int k;
        int f0;
        k = 0;
        f0 = host_u.frames;
        pay = {};
        repeat (n) pay.push_back(8'($random(seed)));
        @(posedge clk_i);
        pkt_valid_i <= 1'b1;
        pkt_zdo_i <= zdo;
        pkt_len_i <= 16'(n);
        pkt_dst_ep_i <= dep;
        {pkt_src64_i, pkt_src16_i, pkt_cluster_i} <= {$random(seed), $random(seed), $random(seed)};
        {pkt_profile_i, pkt_src_ep_i, pkt_options_i} <= $random(seed);
        do tick(k); while (pkt_ready_o !== 1'b1);
        pkt_valid_i <= 1'b0;
        foreach (pay[i]) begin
            pay_valid_i <= 1'b1;
            pay_data_i <= pay[i];
            do tick(k); while (pay_ready_o !== 1'b1);
        end
        pay_valid_i <= 1'b0;
        build(ex);
        if ((zdo && !ex) || n > 6) begin
            nd++;
            repeat (30) @(posedge clk_i);
            cmp(host_u.rx_q.size(), 0, "drop");
        end else begin
            nf++;
            do tick(k); while (host_u.frames == f0);
            cmp(host_u.rx_q.size(), exp_q.size(), "size");
            foreach (exp_q[i]) cmp(host_u.rx_q[i], exp_q[i], "byte");
            cmp(host_u.bad, 0, "host");
            host_u.rx_q = {};
        end
    endtask : frame

    // Reset, then every option mode with endpoint corners and a ZDO packet
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        bus(1'b0, 4'h0, '0);
        cmp(rd, 32'h0000_0000, "ctrl reset");
        bus(1'b0, 4'h2, '0);
        cmp(rd, 32'h0000_0000, "unmapped");
        foreach (modes[m]) begin
            bus(1'b1, 4'h0, modes[m]);
            bus(1'b0, 4'h0, '0);
            cmp(rd, modes[m], "ctrl");
            for (int i = 0; i < 5; i++)
                frame(modes[m][1], i == 4, i == 0 ? 0 : {$random(seed)} % 7,
                    i == 4 ? 8'h00 : dep_tab[i]);
            bus(1'b0, 4'h4, '0);
            cmp(rd, {30'h0000_0000, modes[m][1], 1'b0}, "status");
            $display("mode %h done", modes[m]);
        end
        // Oversize packet is drained without output; counter writes are ignored
        frame(1'b0, 1'b0, 7, 8'hDC);
        bus(1'b1, 4'h8, 32'hFFFF_FFFF);
        bus(1'b0, 4'h8, '0);
        cmp(rd, nf, "frames");
        bus(1'b0, 4'hC, '0);
        cmp(rd, nd, "drops");
        finish_test();
    end
endmodule : test_explicit_receive_frame_builder
`default_nettype wire

// File: hdl/explicit_receive_frame_builder.sv
// Receive frame builder: explicit (or standard) receive frames out to the host serial stream
`timescale 1ns/100ps
`default_nettype none
`include "rx_frame_defines.svh"

module explicit_receive_frame_builder #(
    parameter logic [15:0] MAX_PAYLOAD = 16'd65517
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // Avalon-MM register port
    input  wire logic [3:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    output var  logic [31:0]         avs_readdata_o,
    output var  logic                avs_waitrequest_o,
    // Received packet descriptor
    input  wire logic                pkt_valid_i,
    output var  logic                pkt_ready_o,
    input  wire logic [63:0]         pkt_src64_i,
    input  wire logic [15:0]         pkt_src16_i,
    input  wire frame_pkg::byte_t    pkt_src_ep_i,
    input  wire frame_pkg::byte_t    pkt_dst_ep_i,
    input  wire logic [15:0]         pkt_cluster_i,
    input  wire logic [15:0]         pkt_profile_i,
    input  wire frame_pkg::byte_t    pkt_options_i,
    input  wire logic                pkt_zdo_i,
    input  wire logic [15:0]         pkt_len_i,
    // Payload byte stream
    input  wire logic                pay_valid_i,
    input  wire frame_pkg::byte_t    pay_data_i,
    output var  logic                pay_ready_o,
    // Host serial byte stream
    output var  logic                ser_valid_o,
    output var  frame_pkg::byte_t    ser_data_o,
    output var  logic                ser_last_o,
    input  wire logic                ser_ready_i
);
    import frame_pkg::*;

    // ********************************
    // Declarations
    // ********************************
    frame_state_e state_reg;
    frame_state_e state_next;
    rx_fields_s   fld_reg;
    logic [4:0]   hdr_idx_reg;
    logic [15:0]  pay_left_reg;
    logic         explicit_reg;
    logic         pkt_ready_reg;
    logic         pay_ready_reg;
    logic         ser_valid_reg;
    byte_t        ser_data_reg;
    logic         ser_last_reg;

    logic         slot_free;
    logic         pkt_take;
    logic         pay_take;
    logic         explicit_sel;
    logic         drop_pkt;
    logic [4:0]   hdr_len;
    logic         hdr_last;
    logic [15:0]  frame_len;
    logic         ep_vendor;
    byte_t        opts_eff;
    logic [167:0] hdr_vec;
    logic [167:0] hdr_shift;
    byte_t        hdr_byte;
    logic         hdr_load;
    logic         pay_load;
    logic         csum_load;
    logic         ser_fire;
    byte_t        ser_data_next;

    sum_if sum ();
    cfg_if cfg ();

    // ********************************
    // Submodules
    // ********************************
    frame_checksum u_checksum (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .sum     (sum.acc)
    );

    frame_regs u_regs (
        .clk_i             (clk_i),
        .rst_b_i           (rst_b_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .cfg               (cfg.regs)
    );

    // ********************************
    // Handshakes and packet admission
    // ********************************
    // Same-clock partners, so no synchronisers on these strobes
    assign slot_free    = !ser_valid_reg || ser_ready_i;
    assign pkt_take     = pkt_valid_i && pkt_ready_reg;
    assign pay_take     = pay_valid_i && pay_ready_reg;
    assign explicit_sel = cfg.option[`OPT_EXPLICIT_BIT];
    // ZDO answers only make sense as explicit frames; oversize would wrap the length
    assign drop_pkt     = (pkt_zdo_i && !explicit_sel) || (pkt_len_i > MAX_PAYLOAD);

    // ********************************
    // Header assembly
    // ********************************
    assign hdr_len   = explicit_reg ? `HDR_LEN_EXPLICIT : `HDR_LEN_STANDARD;
    assign hdr_last  = (hdr_idx_reg == hdr_len - 5'd1);
    assign frame_len = {11'd0, hdr_len} - 16'd3 + fld_reg.pay_len;
    // Flag meanings hold on the vendor endpoint range and in standard frames; elsewhere ack/broadcast
    assign ep_vendor = (fld_reg.dst_ep >= `EP_VENDOR_LO) && (fld_reg.dst_ep <= `EP_VENDOR_HI);
    assign opts_eff  = (ep_vendor || !explicit_reg) ? (fld_reg.options & `OPT_MASK_VENDOR)
                                                     : (fld_reg.options & `OPT_MASK_OTHER);
    // All header fields go out MSB first; payload passes untouched so ZDO stays LSB first
    assign hdr_vec = explicit_reg ?
        {`START_DELIM, frame_len, `TYPE_EXPLICIT, fld_reg.src64, fld_reg.src16,
         fld_reg.src_ep, fld_reg.dst_ep, fld_reg.cluster, fld_reg.profile,
         opts_eff} :
        {`START_DELIM, frame_len, `TYPE_STANDARD, fld_reg.src64, fld_reg.src16,
         opts_eff, 48'h0000_0000_0000};
    assign hdr_shift = hdr_vec << {hdr_idx_reg, 3'b000};
    assign hdr_byte  = hdr_shift[167:160];

    // ********************************
    // Output byte selection
    // ********************************
    assign hdr_load  = (state_reg == ST_HDR) && slot_free;
    assign pay_load  = (state_reg == ST_PAY) && pay_take;
    assign csum_load = (state_reg == ST_CSUM) && slot_free;
    assign ser_fire  = hdr_load || pay_load || csum_load;
    assign ser_data_next = hdr_load ? hdr_byte :
                           pay_load ? pay_data_i : sum.chk;

    // Checksum feed: everything from the type byte up to the checksum
    assign sum.clear = pkt_take;
    assign sum.fire  = (hdr_load && hdr_idx_reg >= `CSUM_FIRST_OFS) || pay_load;
    assign sum.data  = hdr_load ? hdr_byte : pay_data_i;

    // Status toward the register block
    assign cfg.frame_done    = csum_load && ser_fire;
    assign cfg.drop          = pkt_take && drop_pkt;
    assign cfg.busy          = (state_reg != ST_IDLE);
    assign cfg.explicit_mode = explicit_reg;

    // ********************************
    // Frame sequencer
    // ********************************
    // Next state of the sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (pkt_take && drop_pkt) begin
                    state_next = (pkt_len_i == 16'h0000) ? ST_IDLE : ST_DRAIN;
                end else if (pkt_take) begin
                    state_next = ST_HDR;
                end
            end
            ST_HDR: begin
                if (hdr_load && hdr_last) begin
                    state_next = (fld_reg.pay_len == 16'h0000) ? ST_CSUM : ST_PAY;
                end
            end
            ST_PAY: begin
                if (pay_take && pay_left_reg == 16'h0001) begin
                    state_next = ST_CSUM;
                end
            end
            ST_CSUM: begin
                if (csum_load) begin
                    state_next = ST_IDLE;
                end
            end
            ST_DRAIN: begin
                if (pay_take && pay_left_reg == 16'h0001) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State, field capture and counters
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg    <= ST_IDLE;
            fld_reg      <= '0;
            hdr_idx_reg  <= 5'd0;
            pay_left_reg <= 16'h0000;
            explicit_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (pkt_take) begin
                fld_reg      <= {pkt_src64_i, pkt_src16_i, pkt_src_ep_i, pkt_dst_ep_i,
                                 pkt_cluster_i, pkt_profile_i, pkt_options_i, pkt_len_i};
                explicit_reg <= explicit_sel;
                pay_left_reg <= pkt_len_i;
                hdr_idx_reg  <= 5'd0;
            end else begin
                if (hdr_load) begin
                    hdr_idx_reg <= hdr_idx_reg + 5'd1;
                end
                if (pay_take) begin
                    pay_left_reg <= pay_left_reg - 16'h0001;
                end
            end
        end
    end

    // Handshake outputs; in ST_PAY payload ready is raised only once the output slot is free, in ST_DRAIN at once
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pkt_ready_reg <= 1'b0;
            pay_ready_reg <= 1'b0;
        end else begin
            pkt_ready_reg <= (state_next == ST_IDLE) && !pkt_take;
            pay_ready_reg <= ((state_reg == ST_PAY) && !pay_take && (pay_ready_reg || slot_free))
                          || ((state_reg == ST_DRAIN) && !(pay_take && pay_left_reg == 16'h0001));
        end
    end

    // Serial output register holds a byte until the host takes it
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ser_valid_reg <= 1'b0;
            ser_data_reg  <= 8'h00;
            ser_last_reg  <= 1'b0;
        end else begin
            ser_valid_reg <= ser_fire || (ser_valid_reg && !ser_ready_i);
            if (ser_fire) begin
                ser_data_reg <= ser_data_next;
                ser_last_reg <= csum_load;
            end
        end
    end

    assign pkt_ready_o = pkt_ready_reg;
    assign pay_ready_o = pay_ready_reg;
    assign ser_valid_o = ser_valid_reg;
    assign ser_data_o  = ser_data_reg;
    assign ser_last_o  = ser_last_reg;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Helper: reference sum of accepted bytes from offset three on
    logic [15:0] chk_ofs_reg;
    byte_t       chk_sum_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            chk_ofs_reg <= 16'h0000;
            chk_sum_reg <= 8'h00;
        end else if (ser_valid_o && ser_ready_i) begin
            chk_ofs_reg <= ser_last_o ? 16'h0000 : chk_ofs_reg + 16'h0001;
            chk_sum_reg <= ser_last_o ? 8'h00 :
                           (chk_ofs_reg >= 16'd3) ? chk_sum_reg + ser_data_o : chk_sum_reg;
        end
    end

    property p_select_mode;
        pkt_take && !drop_pkt |=> explicit_reg == $past(cfg.option[`OPT_EXPLICIT_BIT]);
    endproperty
    a_select_mode: assert property (p_select_mode) else $error("mode not latched");

    property p_start_delim;
        hdr_load && hdr_idx_reg == 5'd0 |=> ser_valid_o && ser_data_o == `START_DELIM;
    endproperty
    a_start_delim: assert property (p_start_delim) else $error("bad delimiter");

    property p_length;
        hdr_load && hdr_idx_reg == `OFS_LEN_LO
            |=> ser_data_o == 8'(fld_reg.pay_len + (explicit_reg ? 16'd18 : 16'd12));
    endproperty
    a_length: assert property (p_length) else $error("bad length low byte");

    property p_type_explicit;
        hdr_load && hdr_idx_reg == `OFS_TYPE && explicit_reg |=> ser_data_o == `TYPE_EXPLICIT;
    endproperty
    a_type_explicit: assert property (p_type_explicit) else $error("bad explicit type");

    property p_type_standard;
        hdr_load && hdr_idx_reg == `OFS_TYPE && !explicit_reg |=> ser_data_o == `TYPE_STANDARD;
    endproperty
    a_type_standard: assert property (p_type_standard) else $error("bad standard type");

    property p_src64_msb;
        hdr_load && hdr_idx_reg == `OFS_SRC64 |=> ser_data_o == fld_reg.src64[63:56];
    endproperty
    a_src64_msb: assert property (p_src64_msb) else $error("long address not MSB first");

    property p_src_ep;
        hdr_load && explicit_reg && hdr_idx_reg == `OFS_SRC_EP ##1 ser_valid_o && ser_ready_i
            |=> ser_data_o == fld_reg.dst_ep;
    endproperty
    a_src_ep: assert property (p_src_ep) else $error("endpoint order wrong");

    property p_options_reserved;
        hdr_load && explicit_reg && hdr_idx_reg == `OFS_OPTIONS |=> ser_data_o[3:2] == 2'b00;
    endproperty
    a_options_reserved: assert property (p_options_reserved) else $error("reserved option set");

    property p_payload_pass;
        pay_load |=> ser_valid_o && ser_data_o == $past(pay_data_i);
    endproperty
    a_payload_pass: assert property (p_payload_pass) else $error("payload byte altered");

    property p_checksum;
        ser_valid_o && ser_ready_i && ser_last_o |-> ser_data_o == `CSUM_BASE - chk_sum_reg;
    endproperty
    a_checksum: assert property (p_checksum) else $error("bad checksum");

    property p_hold;
        ser_valid_o && !ser_ready_i |=> ser_valid_o && $stable(ser_data_o) && $stable(ser_last_o);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");

    property p_zdo_drop;
        pkt_take && pkt_zdo_i && !cfg.option[`OPT_EXPLICIT_BIT] |=> state_reg != ST_HDR;
    endproperty
    a_zdo_drop: assert property (p_zdo_drop) else $error("ZDO sent as standard frame");

    c_explicit_frame: cover property (csum_load && explicit_reg);
    c_standard_frame: cover property (csum_load && !explicit_reg);
    c_drained_packet: cover property (state_reg == ST_DRAIN ##1 state_reg == ST_IDLE);
    c_host_stall:     cover property ((ser_valid_o && !ser_ready_i) [*3]);
endmodule : explicit_receive_frame_builder

`default_nettype wire

// File: hdl/frame_checksum.sv
// Running checksum of the bytes from the frame type onward
`timescale 1ns/100ps
`default_nettype none
`include "rx_frame_defines.svh"

module frame_checksum (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Byte feed
    sum_if.acc        sum
);
    import frame_pkg::*;

    byte_t acc_reg;

    // Sum wraps naturally at eight bits
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || sum.clear) begin
            acc_reg <= 8'h00;
        end else if (sum.fire) begin
            acc_reg <= acc_reg + sum.data;
        end
    end

    assign sum.chk = `CSUM_BASE - acc_reg;
endmodule : frame_checksum

`default_nettype wire

// File: hdl/frame_links.sv
// Interfaces between the frame builder core, its checksum unit and its register block
`timescale 1ns/100ps
`default_nettype none

// Byte feed into the checksum accumulator
interface sum_if;
    logic       clear;
    logic       fire;
    logic [7:0] data;
    logic [7:0] chk;
    modport feed (output clear, output fire, output data, input chk);
    modport acc  (input clear, input fire, input data, output chk);
endinterface : sum_if

// Configuration and status between core and register block
interface cfg_if;
    logic [7:0] option;
    logic       frame_done;
    logic       drop;
    logic       busy;
    logic       explicit_mode;
    modport core (input option, output frame_done, output drop, output busy,
                  output explicit_mode);
    modport regs (output option, input frame_done, input drop, input busy,
                  input explicit_mode);
endinterface : cfg_if

`default_nettype wire

// File: hdl/frame_pkg.sv
// Types shared by the explicit receive frame builder modules
package frame_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_PAY, ST_CSUM, ST_DRAIN} frame_state_e;
    typedef logic [7:0] byte_t;
    typedef struct packed {
        logic [63:0] src64;
        logic [15:0] src16;
        byte_t       src_ep;
        byte_t       dst_ep;
        logic [15:0] cluster;
        logic [15:0] profile;
        byte_t       options;
        logic [15:0] pay_len;
    } rx_fields_s;
endpackage : frame_pkg

// File: hdl/frame_regs.sv
// Avalon-MM register block: output option setting and frame status
`timescale 1ns/100ps
`default_nettype none
`include "rx_frame_defines.svh"

module frame_regs (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output var  logic [31:0] avs_readdata_o,
    output var  logic        avs_waitrequest_o,
    // Core side
    cfg_if.regs              cfg
);
    import frame_pkg::*;

    logic [7:0]  option_reg;
    logic [15:0] frames_reg;
    logic [15:0] drops_reg;
    logic        answer_w;
    logic        commit_w;
    logic [31:0] rd_mux_w;

    // One wait cycle, then the answer; writes land only on the answer edge
    assign answer_w = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    assign commit_w = avs_write_i && !avs_waitrequest_o;
    assign rd_mux_w = (avs_address_i == `REG_CTRL)   ? {24'h00_0000, option_reg} :
                      (avs_address_i == `REG_STATUS) ? {30'h0000_0000, cfg.explicit_mode,
                                                        cfg.busy} :
                      (avs_address_i == `REG_FRAMES) ? {16'h0000, frames_reg} :
                      (avs_address_i == `REG_DROPS)  ? {16'h0000, drops_reg} :
                      32'h0000_0000;
    assign cfg.option = option_reg;

    // Bus handshake and read data
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= !answer_w;
            if (answer_w) begin
                avs_readdata_o <= rd_mux_w;
            end
        end
    end

    // Option setting and event counters; counters wrap
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            option_reg <= `CTRL_RESET;
            frames_reg <= 16'h0000;
            drops_reg  <= 16'h0000;
        end else begin
            if (commit_w && avs_address_i == `REG_CTRL) begin
                option_reg <= avs_writedata_i[7:0];
            end
            if (cfg.frame_done) begin
                frames_reg <= frames_reg + 16'h0001;
            end
            if (cfg.drop) begin
                drops_reg <= drops_reg + 16'h0001;
            end
        end
    end
endmodule : frame_regs

`default_nettype wire

// File: hdl/rx_frame_defines.svh
// Constants for the explicit receive frame builder: codes, offsets, masks, register map
`ifndef RX_FRAME_DEFINES_SVH
`define RX_FRAME_DEFINES_SVH

// ********************************
// Frame codes and layout
// ********************************
`define START_DELIM       8'h7E
`define TYPE_EXPLICIT     8'h91
`define TYPE_STANDARD     8'h90
`define HDR_LEN_EXPLICIT  5'd21
`define HDR_LEN_STANDARD  5'd15
`define OFS_LEN_HI        5'd1
`define OFS_LEN_LO        5'd2
`define OFS_TYPE          5'd3
`define OFS_SRC64         5'd4
`define OFS_SRC_EP        5'd14
`define OFS_OPTIONS       5'd20
`define CSUM_FIRST_OFS    5'd3
`define CSUM_BASE         8'hFF

// ********************************
// Receive options handling
// ********************************
`define OPT_EXPLICIT_BIT  1
`define EP_VENDOR_LO      8'hDC
`define EP_VENDOR_HI      8'hEE
`define OPT_MASK_VENDOR   8'hF3
`define OPT_MASK_OTHER    8'h03

// ********************************
// Register map (byte addresses) and resets
// ********************************
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_FRAMES        4'h8
`define REG_DROPS         4'hC
`define CTRL_RESET        8'h00

`endif
